// File: hdl/pfm_pin_mux.sv
`timescale 1ns/1ps
module pfm_pin_mux
(
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// pins seen from inside
	input  wire logic [3:0] i_port2_upper_bits_pin,
	input  wire logic [7:0] i_port4_pin,
	input  wire logic [7:0] i_port5_open_drain_bits_pin,
	input  wire logic [6:0] i_port6_bits_pin,
	input  wire logic       i_three_phase_kill_input,
	input  wire logic [2:0] i_mode_select_pins,
	input  wire logic       i_reset_request_n,
	// port data and direction
	input  wire logic [3:0] i_port2_dout,
	input  wire logic [3:0] i_port2_dir,
	input  wire logic [5:0] i_port4_dout,
	input  wire logic [5:0] i_port4_dir,
	input  wire logic [7:0] i_port5_dout,
	input  wire logic [7:0] i_port5_dir,
	input  wire logic [6:0] i_port6_dout,
	input  wire logic [6:0] i_port6_dir,
	// peripheral outputs and selections
	input  wire logic [3:0] i_reload_timer_out,
	input  wire logic [3:0] i_reload_timer_sel,
	input  wire logic       i_serial_tx_data,
	input  wire logic       i_serial_tx_sel,
	input  wire logic       i_serial_clk_out,
	input  wire logic       i_serial_clk_sel,
	input  wire logic       i_serial_rx_en,
	input  wire logic       i_pwm_out,
	input  wire logic       i_pwm_sel,
	input  wire logic [7:0] i_analog_input_sel,
	input  wire logic [3:0] i_mft_waveform,
	input  wire logic       i_mft_sel,
	input  wire logic [5:0] i_three_phase_wave,
	input  wire logic       i_three_phase_sel,
	input  wire logic [7:0] i_ext_irq_en,
	input  wire logic       i_timer_clear_trigger_en,
	input  wire logic       i_adc_start_trigger_en,
	// pin drive
	output logic      [3:0] o_port2_out,
	output logic      [3:0] o_port2_oe,
	output logic      [7:0] o_port4_out,
	output logic      [7:0] o_port4_oe,
	output logic      [7:0] o_port5_out,
	output logic      [7:0] o_port5_oe,
	output logic      [6:0] o_port6_out,
	output logic      [6:0] o_port6_oe,
	// port read values
	output logic      [3:0] o_port2_in,
	output logic      [7:0] o_port4_in,
	output logic      [7:0] o_port5_in,
	output logic      [6:0] o_port6_in,
	// peripheral inputs
	output logic      [3:0] o_reload_timer_pin,
	output logic            o_serial_rx_pin,
	output logic            o_serial_clk_in,
	output logic      [7:0] o_ext_irq_input,
	output logic            o_timer_clear_trigger,
	output logic            o_adc_start_trigger,
	output logic      [7:0] o_analog_input_pin,
	output logic            o_three_phase_killed,
	output logic      [2:0] o_mode_select,
	output logic            o_reset_request
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [31:0] s1;
		logic [31:0] s2;
		logic [31:0] s3;
		logic [31:0] flt;
		logic [3:0]  p2_out;
		logic [3:0]  p2_oe;
		logic [7:0]  p4_out;
		logic [7:0]  p4_oe;
		logic [7:0]  p5_out;
		logic [7:0]  p5_oe;
		logic [6:0]  p6_out;
		logic [6:0]  p6_oe;
		logic [3:0]  p2_in;
		logic [7:0]  p4_in;
		logic [7:0]  p5_in;
		logic [6:0]  p6_in;
		logic [3:0]  tmr_in;
		logic        rx;
		logic        sck_in;
		logic [7:0]  irq;
		logic        clr_trig;
		logic        adc_trig;
		logic [7:0]  ana;
		logic        kill;
		logic [2:0]  mode;
		logic        rst_req;
	} pfm_state_s;

	pfm_state_s st_q;
	pfm_state_s st_d;

	// ==========================================================
	// next state
	always_comb
	begin
		logic [31:0] f;
		logic        tp_en;
		f     = '0;
		tp_en = 1'b0;
		st_d  = st_q;
		// s1 is read only by s2; a change counts once s2 and s3 agree
		st_d.s1  = {i_reset_request_n, i_mode_select_pins, i_three_phase_kill_input,
			i_port6_bits_pin, i_port5_open_drain_bits_pin, i_port4_pin,
			i_port2_upper_bits_pin};
		st_d.s2  = st_q.s1;
		st_d.s3  = st_q.s2;
		st_d.flt = (st_q.s2 & st_q.s3) | (st_q.flt & (st_q.s2 ^ st_q.s3));
		f        = st_q.flt;

		// reload timer pins
		for (int i = 0; i < 4; i++)
		begin
			st_d.p2_out[i] = i_reload_timer_sel[i] ? i_reload_timer_out[i] : i_port2_dout[i];
			st_d.p2_oe[i]  = i_reload_timer_sel[i] | i_port2_dir[i];
		end

		// port4: rx, tx, sck, pwm, irq0/1, input-only 6/7
		st_d.p4_out    = '0;
		st_d.p4_oe     = '0;
		st_d.p4_out[0] = i_port4_dout[0];
		st_d.p4_oe[0]  = i_port4_dir[0];
		st_d.p4_out[1] = i_serial_tx_sel ? i_serial_tx_data : i_port4_dout[1];
		st_d.p4_oe[1]  = i_serial_tx_sel | i_port4_dir[1];
		st_d.p4_out[2] = i_serial_clk_sel ? i_serial_clk_out : i_port4_dout[2];
		st_d.p4_oe[2]  = i_serial_clk_sel | i_port4_dir[2];
		st_d.p4_out[3] = i_pwm_sel ? i_pwm_out : i_port4_dout[3];
		st_d.p4_oe[3]  = i_pwm_sel | i_port4_dir[3];
		st_d.p4_out[5:4] = i_port4_dout[5:4];
		st_d.p4_oe[5:4]  = i_port4_dir[5:4];
		// bits 7:6 stay zero: no driver behind them

		// port5: open drain, only ever pulls low; analog owns the pin when selected
		st_d.p5_out = '0;
		st_d.p5_oe  = ~i_analog_input_sel & i_port5_dir & ~i_port5_dout;
		st_d.ana    = i_analog_input_sel;

		// port6: 3-phase over timer over port
		tp_en     = i_three_phase_sel & ~f[pfm_pkg::IDX_KILL];
		st_d.kill = f[pfm_pkg::IDX_KILL];
		for (int i = 0; i < 3; i++)
		begin
			if (tp_en)
				st_d.p6_out[i] = i_three_phase_wave[i];
			else if (i_mft_sel)
				st_d.p6_out[i] = i_mft_waveform[i + 1];
			else
				st_d.p6_out[i] = i_port6_dout[i];
			st_d.p6_oe[i] = tp_en | i_mft_sel | i_port6_dir[i];
		end
		for (int i = 3; i < 6; i++)
		begin
			st_d.p6_out[i] = tp_en ? i_three_phase_wave[i] : i_port6_dout[i];
			st_d.p6_oe[i]  = tp_en | i_port6_dir[i];
		end
		st_d.p6_out[6] = i_mft_sel ? i_mft_waveform[0] : i_port6_dout[6];
		st_d.p6_oe[6]  = i_mft_sel | i_port6_dir[6];

		// port read values; analog pins read low to keep the digital path quiet
		st_d.p2_in = f[pfm_pkg::IDX_P2 +: 4];
		st_d.p4_in = f[pfm_pkg::IDX_P4 +: 8];
		st_d.p5_in = f[pfm_pkg::IDX_P5 +: 8] & ~i_analog_input_sel;
		st_d.p6_in = f[pfm_pkg::IDX_P6 +: 7];

		// peripheral inputs, gated by their enables; idle level is high for serial receive, serial clock and reload timer inputs are ungated
		st_d.tmr_in = f[pfm_pkg::IDX_P2 +: 4];
		st_d.rx     = i_serial_rx_en ? f[pfm_pkg::IDX_P4] : 1'b1;
		st_d.sck_in = f[pfm_pkg::IDX_P4 + 2];
		st_d.irq    = i_ext_irq_en & {f[pfm_pkg::IDX_P2 +: 4], f[pfm_pkg::IDX_P4 + 4 +: 4]};
		st_d.clr_trig = i_timer_clear_trigger_en & f[pfm_pkg::IDX_P4 + 6];
		st_d.adc_trig = i_adc_start_trigger_en & f[pfm_pkg::IDX_P4 + 7];

		// straps tied to rails, so the filtered level is simply passed on
		st_d.mode    = f[pfm_pkg::IDX_MODE +: 3];
		// two agreeing samples suffice; a five-cycle hold is always seen
		st_d.rst_req = ~f[pfm_pkg::IDX_RST];
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_q     <= '0;
			st_q.s1  <= pfm_pkg::PIN_IDLE;
			st_q.s2  <= pfm_pkg::PIN_IDLE;
			st_q.s3  <= pfm_pkg::PIN_IDLE;
			st_q.flt <= pfm_pkg::PIN_IDLE;
			st_q.rx  <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// ==========================================================
	// outputs
	assign o_port2_out           = st_q.p2_out;
	assign o_port2_oe            = st_q.p2_oe;
	assign o_port4_out           = st_q.p4_out;
	assign o_port4_oe            = st_q.p4_oe;
	assign o_port5_out           = st_q.p5_out;
	assign o_port5_oe            = st_q.p5_oe;
	assign o_port6_out           = st_q.p6_out;
	assign o_port6_oe            = st_q.p6_oe;
	assign o_port2_in            = st_q.p2_in;
	assign o_port4_in            = st_q.p4_in;
	assign o_port5_in            = st_q.p5_in;
	assign o_port6_in            = st_q.p6_in;
	assign o_reload_timer_pin    = st_q.tmr_in;
	assign o_serial_rx_pin       = st_q.rx;
	assign o_serial_clk_in       = st_q.sck_in;
	assign o_ext_irq_input       = st_q.irq;
	assign o_timer_clear_trigger = st_q.clr_trig;
	assign o_adc_start_trigger   = st_q.adc_trig;
	assign o_analog_input_pin    = st_q.ana;
	assign o_three_phase_killed  = st_q.kill;
	assign o_mode_select         = st_q.mode;
	assign o_reset_request       = st_q.rst_req;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_rst_low;
		!i_reset_request_n [*4];
	endsequence

	sequence s_mode_hi;
		i_mode_select_pins[0] [*4];
	endsequence

	sequence s_rx_pin_low;
		!i_port4_pin[0] [*4];
	endsequence

	chk_timer_pin_drive: assert property (i_reload_timer_sel[2] |=>
		o_port2_oe[2] && o_port2_out[2] == $past(i_reload_timer_out[2]))
		else $error("reload timer pin not driven by timer");
	chk_timer_pin_port: assert property (!i_reload_timer_sel[1] |=>
		o_port2_oe[1] == $past(i_port2_dir[1]) && o_port2_out[1] == $past(i_port2_dout[1]))
		else $error("reload timer pin not a port bit");
	chk_tx_pin_drive: assert property (i_serial_tx_sel |=>
		o_port4_oe[1] && o_port4_out[1] == $past(i_serial_tx_data))
		else $error("transmit pin not driven by serial port");
	chk_sck_pin_drive: assert property (i_serial_clk_sel |=>
		o_port4_oe[2] && o_port4_out[2] == $past(i_serial_clk_out))
		else $error("serial clock pin not driven");
	chk_pwm_pin_drive: assert property ($rose(i_pwm_sel) |=>
		o_port4_oe[3] && o_port4_out[3] == $past(i_pwm_out))
		else $error("pulse pin not driven by generator");
	chk_pwm_port_bit: assert property (!i_pwm_sel |=>
		o_port4_oe[3] == $past(i_port4_dir[3]) && o_port4_out[3] == $past(i_port4_dout[3]))
		else $error("pulse pin not a port bit");
	chk_rx_port_bit: assert property (1'b1 |=>
		o_port4_oe[0] == $past(i_port4_dir[0]) && o_port4_out[0] == $past(i_port4_dout[0]))
		else $error("receive pin lost its port function");
	chk_od_never_high: assert property (o_port5_out == 8'h00 &&
		(o_port5_oe & $past(i_analog_input_sel)) == 8'h00)
		else $error("open-drain pin driven high or while analog");
	chk_phase_wins: assert property (i_three_phase_sel && i_mft_sel &&
		!st_q.flt[pfm_pkg::IDX_KILL] |=> o_port6_out[0] == $past(i_three_phase_wave[0]))
		else $error("timer waveform beat 3-phase output");
	chk_shared_port: assert property (!i_three_phase_sel && !i_mft_sel |=>
		o_port6_oe[2:0] == $past(i_port6_dir[2:0]))
		else $error("shared port6 pin not a port bit");
	chk_phase_only: assert property (i_three_phase_sel && !st_q.flt[pfm_pkg::IDX_KILL] |=>
		o_port6_oe[5:3] == 3'h7 && o_port6_out[5:3] == $past(i_three_phase_wave[5:3]))
		else $error("3-phase pin missing its phase");
	chk_wave_zero_pin: assert property (i_mft_sel |=>
		o_port6_oe[6] && o_port6_out[6] == $past(i_mft_waveform[0]))
		else $error("timer waveform zero not on its pin");
	chk_kill_stops: assert property (st_q.flt[pfm_pkg::IDX_KILL] |=>
		o_three_phase_killed && o_port6_oe[3] == $past(i_port6_dir[3]))
		else $error("kill input left 3-phase output on");
	chk_rx_gated: assert property (s_rx_pin_low ##0 i_serial_rx_en [*3] |=>
		!o_serial_rx_pin)
		else $error("receiver missed low receive pin");
	chk_rx_idle: assert property (!i_serial_rx_en |=> o_serial_rx_pin)
		else $error("receiver saw pin while disabled");
	chk_irq_gated: assert property (1'b1 |=>
		(o_ext_irq_input & ~$past(i_ext_irq_en)) == 8'h00)
		else $error("interrupt level passed while disabled");
	chk_clear_trig_gated: assert property (!i_timer_clear_trigger_en |=> !o_timer_clear_trigger)
		else $error("clear trigger passed while disabled");
	chk_start_trig_gated: assert property (!i_adc_start_trigger_en |=> !o_adc_start_trigger)
		else $error("start trigger passed while disabled");
	chk_input_only: assert property (o_port4_oe[7:6] == 2'h0)
		else $error("input-only pin driven");
	chk_mode_follow: assert property (s_mode_hi |-> ##2 o_mode_select[0])
		else $error("mode strap not reflected");
	chk_reset_req: assert property (s_rst_low |-> ##2 o_reset_request)
		else $error("reset request pin not taken");

endmodule : pfm_pin_mux

// File: include/pfm_pkg.sv
// Notes on behaviour
// - port2 upper pins are port bits unless their reload timer output is selected.
// - transmit pin carries serial data when selected, otherwise it is a port bit.
// - serial clock pin outputs shift clock when selected; its level always reaches the serial port.
// - pulse-width pin is driven by the pulse generator when selected, else a port bit.
// - port5 pins are open-drain port bits, or go to the converter when analog is selected.
// - port6 bits 0-2 are port bits only when timer and 3-phase outputs are both off.
// - 3-phase pins carry phases when selected; bits 3-5 are port bits otherwise.
// - port6 bit6 carries timer waveform zero when timer output is selected, else port.
// - a dedicated kill input switches off the 3-phase waveform outputs.
// - receive pin stays a port bit; receiver sees its level only while enabled.
// - interrupt pins stay port bits; each request sees the level only while enabled.
// - input-only port4 bit6 feeds the timer clear trigger only while enabled.
// - input-only port4 bit7 feeds the converter start trigger only while enabled.
// - port4 bits 6 and 7 are input only and never driven.
// - three mode pins give the operating mode as static levels.
// - the reset request pin raises a reset request to the reset logic.
package pfm_pkg;

	// ==========================================================
	// synchroniser vector layout
	localparam int          PIN_W    = 32;
	localparam int          IDX_P2   = 0;
	localparam int          IDX_P4   = 4;
	localparam int          IDX_P5   = 12;
	localparam int          IDX_P6   = 20;
	localparam int          IDX_KILL = 27;
	localparam int          IDX_MODE = 28;
	localparam int          IDX_RST  = 31;
	// idle pin levels: reset request high, kill low
	localparam logic [31:0] PIN_IDLE = 32'hF7FF_FFFF;

	// ==========================================================
	// timing
	localparam int CLK_NS        = 10;
	localparam int MACHINE_NS    = 10;
	localparam int RST_HOLD_MC   = 5;
	localparam int RST_HOLD_CYC  = (RST_HOLD_MC * MACHINE_NS + CLK_NS - 1) / CLK_NS;
	// pin to peripheral after the first sample: two more sync stages, filter and output register
	localparam int SYNC_LAT_CYC  = 4;

endpackage : pfm_pkg

// File: test/pfm_board.sv
`timescale 1ns/1ps
// ==========================================================
// board side of the shared pins
module pfm_board
(
	input  wire logic [26:0] i_out,
	input  wire logic [26:0] i_oe,
	input  wire logic [26:0] i_drv,
	input  wire logic [26:0] i_drv_en,
	output logic      [26:0] o_pin
);
	// released pins rest at the pull-up, never at the last driven value
	// open drain bits only ever pull low, since their out is 0
	always_comb
	begin
		for (int b = 0; b < 27; b++)
			o_pin[b] = i_oe[b] ? i_out[b] : (i_drv_en[b] ? i_drv[b] : 1'b1);
	end
endmodule : pfm_board

// File: test/pfm_pin_mux_tb.sv
`timescale 1ns/1ps
module pfm_pin_mux_tb;
	typedef struct packed {
		logic [3:0] rts, rto;
		logic [2:0] ss, so;
		logic       ms;
		logic [3:0] mw;
		logic       ts;
		logic [5:0] tw;
		logic [3:0] e2oe, e2ov;
		logic [2:0] e4oe, e4ov;
		logic [6:0] e6oe, e6ov;
	} pfm_row_s;
	// ==========================================================
	// stimulus rows: selections, then expected drive
	localparam pfm_row_s ROWS [5] = '{
		'{4'h0, 4'h0, 3'h0, 3'h0, 1'b0, 4'h0, 1'b0, 6'h00, 4'h3, 4'h1, 3'h3, 3'h1, 7'h0F, 7'h05},
		'{4'hC, 4'hA, 3'h7, 3'h5, 1'b1, 4'h6, 1'b0, 6'h00, 4'hF, 4'h9, 3'h7, 3'h5, 7'h4F, 7'h03},
		'{4'h0, 4'h0, 3'h0, 3'h0, 1'b1, 4'hF, 1'b1, 6'h2C, 4'h3, 4'h1, 3'h3, 3'h1, 7'h7F, 7'h6C},
		'{4'h0, 4'h0, 3'h0, 3'h0, 1'b0, 4'h0, 1'b1, 6'h13, 4'h3, 4'h1, 3'h3, 3'h1, 7'h3F, 7'h13},
		'{4'h0, 4'h0, 3'h0, 3'h0, 1'b1, 4'h1, 1'b0, 6'h00, 4'h3, 4'h1, 3'h3, 3'h1, 7'h4F, 7'h40}};
	logic i_clk, i_nrst, i_three_phase_kill_input, i_reset_request_n, i_serial_tx_data;
	logic i_serial_tx_sel, i_serial_clk_out, i_serial_clk_sel, i_serial_rx_en, i_pwm_out;
	logic i_pwm_sel, i_mft_sel, i_three_phase_sel, i_timer_clear_trigger_en, i_adc_start_trigger_en;
	logic [2:0] i_mode_select_pins, o_mode_select;
	logic [3:0] i_port2_dout, i_port2_dir, i_reload_timer_out, i_reload_timer_sel, i_mft_waveform;
	logic [5:0] i_port4_dout, i_port4_dir, i_three_phase_wave;
	logic [7:0] i_port5_dout, i_port5_dir, i_analog_input_sel, i_ext_irq_en;
	logic [6:0] i_port6_dout, i_port6_dir, o_port6_out, o_port6_oe, o_port6_in;
	logic [3:0] o_port2_out, o_port2_oe, o_port2_in, o_reload_timer_pin;
	logic [7:0] o_port4_out, o_port4_oe, o_port5_out, o_port5_oe, o_port4_in, o_port5_in;
	logic [7:0] o_ext_irq_input, o_analog_input_pin;
	logic o_serial_rx_pin, o_serial_clk_in, o_timer_clear_trigger, o_adc_start_trigger;
	logic o_three_phase_killed, o_reset_request;
	logic [26:0] pins, bdrv, ben;
	int n_errors = 0;
	int num_checks = 0;

	pfm_pin_mux u_dut (.i_clk, .i_nrst, .i_port2_upper_bits_pin(pins[3:0]),
		.i_port4_pin(pins[11:4]), .i_port5_open_drain_bits_pin(pins[19:12]),
		.i_port6_bits_pin(pins[26:20]), .i_three_phase_kill_input, .i_mode_select_pins,
		.i_reset_request_n, .i_port2_dout, .i_port2_dir, .i_port4_dout, .i_port4_dir,
		.i_port5_dout, .i_port5_dir, .i_port6_dout, .i_port6_dir, .i_reload_timer_out,
		.i_reload_timer_sel, .i_serial_tx_data, .i_serial_tx_sel, .i_serial_clk_out,
		.i_serial_clk_sel, .i_serial_rx_en, .i_pwm_out, .i_pwm_sel, .i_analog_input_sel,
		.i_mft_waveform, .i_mft_sel, .i_three_phase_wave, .i_three_phase_sel, .i_ext_irq_en,
		.i_timer_clear_trigger_en, .i_adc_start_trigger_en, .o_port2_out, .o_port2_oe,
		.o_port4_out, .o_port4_oe, .o_port5_out, .o_port5_oe, .o_port6_out, .o_port6_oe,
		.o_port2_in, .o_port4_in, .o_port5_in, .o_port6_in, .o_reload_timer_pin,
		.o_serial_rx_pin, .o_serial_clk_in, .o_ext_irq_input, .o_timer_clear_trigger,
		.o_adc_start_trigger, .o_analog_input_pin, .o_three_phase_killed, .o_mode_select,
		.o_reset_request);

	pfm_board u_board (.i_out({o_port6_out, o_port5_out, o_port4_out, o_port2_out}),
		.i_oe({o_port6_oe, o_port5_oe, o_port4_oe, o_port2_oe}), .i_drv(bdrv),
		.i_drv_en(ben), .o_pin(pins));

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask : cyc

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic apply(input pfm_row_s r);
		i_reload_timer_sel = r.rts;
		i_reload_timer_out = r.rto;
		{i_pwm_sel, i_serial_clk_sel, i_serial_tx_sel} = r.ss;
		{i_pwm_out, i_serial_clk_out, i_serial_tx_data} = r.so;
		i_mft_sel = r.ms;
		i_mft_waveform = r.mw;
		i_three_phase_sel = r.ts;
		i_three_phase_wave = r.tw;
	endtask : apply

	// ==========================================================
	// watchdog: whole run is well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge i_clk);
		n_errors++;
		tally_and_finish();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		{i_three_phase_kill_input, i_serial_rx_en, i_timer_clear_trigger_en} = '0;
		{i_adc_start_trigger_en, i_mode_select_pins, i_ext_irq_en, i_analog_input_sel} = '0;
		{i_port5_dout, i_port5_dir, i_port4_dout, bdrv, ben} = '0;
		apply(ROWS[0]);
		i_reset_request_n = 1'b1;
		i_port2_dir = 4'h3;
		i_port2_dout = 4'h5;
		i_port4_dir = 6'h06;
		i_port4_dout = 6'h02;
		i_port6_dir = 7'h0F;
		i_port6_dout = 7'h05;
		i_nrst = 1'b0;
		cyc(3);
		chk("rst p6oe", o_port6_oe, 8'h00);
		chk("rst rx", o_serial_rx_pin, 8'h01);
		i_nrst = 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			apply(ROWS[k]);
			cyc(1);
			chk("p2oe", o_port2_oe, ROWS[k].e2oe);
			chk("p2out", o_port2_out & o_port2_oe, ROWS[k].e2ov);
			chk("p4oe", o_port4_oe[3:1], ROWS[k].e4oe);
			chk("p4out", o_port4_out[3:1] & o_port4_oe[3:1], ROWS[k].e4ov);
			chk("p6oe", o_port6_oe, ROWS[k].e6oe);
			chk("p6out", o_port6_out & o_port6_oe, ROWS[k].e6ov);
		end
		// kill falls back to timer and port, not to a fixed level
		apply(ROWS[2]);
		i_three_phase_kill_input = 1'b1;
		cyc(pfm_pkg::SYNC_LAT_CYC + 1);
		chk("killed", o_three_phase_killed, 8'h01);
		chk("kill oe", o_port6_oe, 8'h4F);
		chk("kill out", o_port6_out & o_port6_oe, 8'h47);
		i_three_phase_kill_input = 1'b0;
		apply(ROWS[0]);
		i_analog_input_sel = 8'hF0;
		i_port5_dir = 8'hFF;
		i_port5_dout = 8'h0A;
		ben[11:4] = 8'hF1;
		bdrv[11:4] = 8'hD0;
		{i_serial_rx_en, i_timer_clear_trigger_en, i_adc_start_trigger_en} = 3'h7;
		i_ext_irq_en = 8'hFF;
		i_mode_select_pins = 3'h5;
		cyc(6);
		chk("p5oe", o_port5_oe, 8'h05);
		chk("p5out", o_port5_out, 8'h00);
		chk("an", o_analog_input_pin, 8'hF0);
		chk("p5in", o_port5_in, 8'h0A);
		chk("p4in", o_port4_in, 8'hDA);
		chk("p4oe hi", o_port4_oe[7:6], 8'h00);
		chk("rx on", o_serial_rx_pin, 8'h00);
		chk("irq on", o_ext_irq_input, 8'hDD);
		chk("tclr on", o_timer_clear_trigger, 8'h01);
		chk("adtr on", o_adc_start_trigger, 8'h01);
		chk("rtpin", o_reload_timer_pin, 8'h0D);
		chk("sclk in", o_serial_clk_in, 8'h00);
		chk("mode", o_mode_select, 8'h05);
		chk("p2in", o_port2_in, 8'h0D);
		chk("p6in", o_port6_in, 8'h75);
		chk("p4oe all", o_port4_oe, 8'h06);
		chk("p4out all", o_port4_out & o_port4_oe, 8'h02);
		{i_serial_rx_en, i_timer_clear_trigger_en, i_adc_start_trigger_en} = 3'h0;
		i_ext_irq_en = 8'h0F;
		cyc(2);
		chk("rx off", o_serial_rx_pin, 8'h01);
		chk("irq part", o_ext_irq_input, 8'h0D);
		chk("tclr off", o_timer_clear_trigger, 8'h00);
		chk("adtr off", o_adc_start_trigger, 8'h00);
		// board holds the request low for the minimum span only
		i_reset_request_n = 1'b0;
		cyc(pfm_pkg::RST_HOLD_CYC);
		chk("rstreq on", o_reset_request, 8'h01);
		i_reset_request_n = 1'b1;
		cyc(6);
		chk("rstreq off", o_reset_request, 8'h00);
		// ==========================================================
		// reset in mid-run: straps restart from the idle level
		i_nrst = 1'b0;
		cyc(1);
		chk("mid rst mode", o_mode_select, 8'h00);
		chk("mid rst rx", o_serial_rx_pin, 8'h01);
		chk("mid rst p6oe", o_port6_oe, 8'h00);
		i_nrst = 1'b1;
		cyc(1);
		chk("idle mode", o_mode_select, pfm_pkg::PIN_IDLE[pfm_pkg::IDX_MODE +: 3]);
		cyc(pfm_pkg::SYNC_LAT_CYC);
		chk("mode back", o_mode_select, 8'h05);
		chk("rstreq idle", o_reset_request, 8'h00);
		tally_and_finish();
	end
endmodule : pfm_pin_mux_tb
